// ==== shared/drain_move_pkg.sv ====
// constants shared by the drain and memory move execution block
package drain_move_pkg;
  // --------------------------------------------------------------
  // operation codes
  // --------------------------------------------------------------
  localparam logic [7:0] OP_DRAIN = 8'h02;
  localparam logic [7:0] OP_MOVE = 8'h03;
  // --------------------------------------------------------------
  // operation-specific flag positions
  // --------------------------------------------------------------
  localparam int FLAG_RB1_VALID = 16;
  localparam int FLAG_RB2_VALID = 17;
  localparam int FLAG_NO_IMPL_TCA = 18;
  localparam int FLAG_NO_IMPL_TCB = 19;
  localparam int FLAG_RSVD_HI = 23;
  localparam int FLAG_RSVD_LO = 20;
  // --------------------------------------------------------------
  // completion status codes
  // --------------------------------------------------------------
  localparam logic [7:0] ST_NONE = 8'h00;
  localparam logic [7:0] ST_SUCCESS = 8'h01;
  localparam logic [7:0] ST_PAGE_FAULT = 8'h03;
  localparam logic [7:0] ST_BAD_OP = 8'h10;
  localparam logic [7:0] ST_OVERLAP = 8'h11;
  localparam logic [7:0] ST_BAD_FLAGS = 8'h12;
  // --------------------------------------------------------------
  // copy direction reported in result
  // --------------------------------------------------------------
  localparam logic DIR_FORWARD = 1'b0;
  localparam logic DIR_REVERSE = 1'b1;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [63:0] RST_ADDR = 64'h0;
  localparam logic [31:0] RST_COUNT = 32'h0;
  // --------------------------------------------------------------
  // state machine
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_RB1 = 3'b010,
    S_RB2 = 3'b011,
    S_IMPL = 3'b100,
    S_RD = 3'b101,
    S_WR = 3'b110,
    S_DONE = 3'b111
  } state_t;
endpackage

// ==== src/drain_and_memory_move_ops.sv ====
// executes drain and memory move descriptors against a byte memory port
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Function
// R1 - drain waits for earlier queue descriptors
// R2 - drain inside batch is unsupported operation
// R3 - software requests record or interrupt on drain
// R4 - drain notification only after waited descriptors
// R5 - readback valid flags reserved without capability
// R6 - selector flag honoured only when valid set
// R7 - bit 19 suppresses second class implicit readback
// R8 - bit 18 suppresses first class implicit readback
// R9 - bit 17 reads address two on selected class
// R10 - bit 16 reads address one on selected class
// R11 - software zeroes drain flag bits 23:20
// R12 - cache control flags reserved for drain
// R13 - move copies transfer size bytes
// R14 - move accepts any byte alignment
// R15 - overlap supported: copy as via temporary buffer
// R16 - overlap unsupported: overlap reports error
// R17 - page fault reports direction in result
// R18 - no overlap support: result always zero
// R19 - software resumes forward by advancing addresses
// R20 - software resumes reverse keeping addresses
// R21 - direction may differ across partial completions
// R22 - partial completion reports bytes and fault address
// --------------------------------------------------------------
module drain_and_memory_move_ops #(
  parameter int XFER_W = 32 // transfer size width
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // descriptor in (same clock, from queue logic)
  input wire logic i_desc_valid,
  input wire logic [7:0] i_desc_op,
  input wire logic [23:0] i_desc_flags, // operation-specific flags
  input wire logic i_desc_in_batch,
  input wire logic i_desc_cache_ctl, // any cache control flag set
  input wire logic i_rb1_tc_sel, // address one class selector
  input wire logic i_rb2_tc_sel, // address two class selector
  input wire logic [63:0] i_src_addr, // also readback address one
  input wire logic [63:0] i_dst_addr, // also readback address two
  input wire logic [XFER_W-1:0] i_xfer_size,
  // capabilities
  input wire logic i_cap_drain_readback,
  input wire logic i_cap_overlap_copy,
  // queue occupancy: earlier descriptors still outstanding
  input wire logic i_wq_older_busy,
  // memory port
  input wire logic i_mem_ready,
  input wire logic i_mem_fault,
  input wire logic [7:0] i_mem_rdata,
  // outputs
  output logic o_desc_ready,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic o_mem_tc, // 0 first class, 1 second class
  output logic o_mem_implicit, // implicit readback, no address
  output logic [63:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_cmp_valid,
  output logic [7:0] o_cmp_status,
  output logic o_cmp_result,
  output logic [XFER_W-1:0] o_cmp_bytes,
  output logic [63:0] o_cmp_fault_addr
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  drain_move_pkg::state_t state_q; // current step
  logic [23:0] flags_q; // latched drain flags
  logic tc1_q; // latched selectors
  logic tc2_q;
  logic impl_tc_q; // implicit readback class in progress
  logic [63:0] src_q; // source base
  logic [63:0] dst_q; // destination base
  logic [XFER_W-1:0] size_q; // transfer size
  logic [XFER_W-1:0] done_q; // bytes written so far
  logic dir_q; // copy direction
  logic [7:0] byte_q; // byte in flight

  // overlap test for two byte regions of equal length
  function automatic logic overlaps(input logic [63:0] a, input logic [63:0] b,
                                    input logic [XFER_W-1:0] n);
    logic [64:0] len;
    // one spare top bit keeps a region at the top of memory from wrapping
    len = 65'(n);
    overlaps = (n != '0) && ({1'b0, a} < {1'b0, b} + len) &&
               ({1'b0, b} < {1'b0, a} + len);
  endfunction

  // byte offset for the current step, honouring direction
  function automatic logic [63:0] offs(input logic d, input logic [XFER_W-1:0] sz,
                                       input logic [XFER_W-1:0] k);
    offs = d ? 64'(sz - k - XFER_W'(1)) : 64'(k);
  endfunction

  logic [63:0] cur_off; // offset of byte being moved
  assign cur_off = offs(dir_q, size_q, done_q);

  // --------------------------------------------------------------
  // descriptor acceptance and sequencing
  // --------------------------------------------------------------
  // one process holds the state; memory request fields ride on it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      // outputs start quiet; ready comes up on the first edge out of reset
      state_q <= drain_move_pkg::S_IDLE;
      flags_q <= '0;
      tc1_q <= 1'b0;
      tc2_q <= 1'b0;
      impl_tc_q <= 1'b0;
      src_q <= drain_move_pkg::RST_ADDR;
      dst_q <= drain_move_pkg::RST_ADDR;
      size_q <= '0;
      done_q <= '0;
      dir_q <= drain_move_pkg::DIR_FORWARD;
      byte_q <= 8'h00;
      o_desc_ready <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_tc <= 1'b0;
      o_mem_implicit <= 1'b0;
      o_mem_addr <= drain_move_pkg::RST_ADDR;
      o_mem_wdata <= 8'h00;
      o_cmp_valid <= 1'b0;
      o_cmp_status <= drain_move_pkg::ST_NONE;
      o_cmp_result <= 1'b0;
      o_cmp_bytes <= '0;
      o_cmp_fault_addr <= drain_move_pkg::RST_ADDR;
    end else begin
      o_cmp_valid <= 1'b0; // completion is a one-cycle pulse
      // ready comes up whenever idle, so an offer held while busy is not shut out
      o_desc_ready <= (state_q == drain_move_pkg::S_IDLE) && !(i_desc_valid && o_desc_ready);
      unique case (state_q)
        drain_move_pkg::S_IDLE: begin
          if (i_desc_valid && o_desc_ready) begin
            flags_q <= i_desc_flags;
            // selectors only count when their valid flag is set
            tc1_q <= i_desc_flags[drain_move_pkg::FLAG_RB1_VALID] & i_rb1_tc_sel; // see R6
            tc2_q <= i_desc_flags[drain_move_pkg::FLAG_RB2_VALID] & i_rb2_tc_sel; // see R6
            src_q <= i_src_addr;
            dst_q <= i_dst_addr;
            size_q <= i_xfer_size;
            done_q <= '0;
            o_cmp_status <= drain_move_pkg::ST_NONE;
            o_cmp_result <= 1'b0;
            o_cmp_bytes <= '0;
            o_cmp_fault_addr <= drain_move_pkg::RST_ADDR;
            // forward unless destination starts inside the source tail
            // chosen afresh for every descriptor, so a resumed move may flip
            dir_q <= (i_cap_overlap_copy && i_dst_addr > i_src_addr &&
                      overlaps(i_src_addr, i_dst_addr, i_xfer_size)); // see R15 see R21
            if (i_desc_op == drain_move_pkg::OP_DRAIN && i_desc_in_batch) begin
              o_cmp_status <= drain_move_pkg::ST_BAD_OP; // see R2
              state_q <= drain_move_pkg::S_DONE;
            end else if (i_desc_op == drain_move_pkg::OP_DRAIN) begin
              // reserved readback and cache bits set are refused
              if ((!i_cap_drain_readback &&
                   (i_desc_flags[drain_move_pkg::FLAG_RB1_VALID] ||
                    i_desc_flags[drain_move_pkg::FLAG_RB2_VALID])) || // see R5
                  i_desc_cache_ctl || // see R12
                  (i_desc_flags[drain_move_pkg::FLAG_RSVD_HI:
                                drain_move_pkg::FLAG_RSVD_LO] != 4'h0)) begin
                o_cmp_status <= drain_move_pkg::ST_BAD_FLAGS;
                state_q <= drain_move_pkg::S_DONE;
              end else begin
                state_q <= drain_move_pkg::S_WAIT; // see R1
              end
            end else if (i_desc_op == drain_move_pkg::OP_MOVE) begin
              if (!i_cap_overlap_copy && overlaps(i_src_addr, i_dst_addr, i_xfer_size)) begin
                o_cmp_status <= drain_move_pkg::ST_OVERLAP; // see R16
                state_q <= drain_move_pkg::S_DONE;
              end else if (i_xfer_size == '0) begin
                o_cmp_status <= drain_move_pkg::ST_SUCCESS;
                state_q <= drain_move_pkg::S_DONE;
              end else begin
                state_q <= drain_move_pkg::S_RD; // see R13
              end
            end else begin
              o_cmp_status <= drain_move_pkg::ST_BAD_OP;
              state_q <= drain_move_pkg::S_DONE;
            end
          end
        end
        drain_move_pkg::S_WAIT: begin
          // hold until every older descriptor of this queue has finished
          if (!i_wq_older_busy) begin // see R1
            state_q <= drain_move_pkg::S_RB1;
          end
        end
        drain_move_pkg::S_RB1: begin
          // explicit readback one, skipped when its valid flag is clear
          if (!flags_q[drain_move_pkg::FLAG_RB1_VALID]) begin
            state_q <= drain_move_pkg::S_RB2;
          end else if (o_mem_req && i_mem_ready) begin
            o_mem_req <= 1'b0;
            state_q <= drain_move_pkg::S_RB2;
          end else if (!o_mem_req) begin
            o_mem_req <= 1'b1; // see R10
            o_mem_we <= 1'b0;
            o_mem_implicit <= 1'b0;
            o_mem_tc <= tc1_q;
            o_mem_addr <= src_q;
          end
        end
        drain_move_pkg::S_RB2: begin
          // explicit readback two, skipped when its valid flag is clear
          if (!flags_q[drain_move_pkg::FLAG_RB2_VALID]) begin
            state_q <= drain_move_pkg::S_IMPL;
            impl_tc_q <= 1'b0;
          end else if (o_mem_req && i_mem_ready) begin
            o_mem_req <= 1'b0;
            state_q <= drain_move_pkg::S_IMPL;
            impl_tc_q <= 1'b0;
          end else if (!o_mem_req) begin
            o_mem_req <= 1'b1; // see R9
            o_mem_we <= 1'b0;
            o_mem_implicit <= 1'b0;
            o_mem_tc <= tc2_q;
            o_mem_addr <= dst_q;
          end
        end
        drain_move_pkg::S_IMPL: begin
          // implicit readback per class, first class then second
          if (flags_q[impl_tc_q ? drain_move_pkg::FLAG_NO_IMPL_TCB
                                : drain_move_pkg::FLAG_NO_IMPL_TCA] || // see R7 see R8
              (o_mem_req && i_mem_ready)) begin
            o_mem_req <= 1'b0;
            o_mem_implicit <= 1'b0;
            impl_tc_q <= 1'b1;
            if (impl_tc_q) begin
              o_cmp_status <= drain_move_pkg::ST_SUCCESS;
              state_q <= drain_move_pkg::S_DONE; // see R4
            end
          end else if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_implicit <= 1'b1;
            // no readback address here; the class alone picks the path to flush
            o_mem_tc <= impl_tc_q;
            o_mem_addr <= drain_move_pkg::RST_ADDR;
          end
        end
        drain_move_pkg::S_RD: begin
          // byte-wide moves make every alignment legal
          if (o_mem_req && i_mem_ready) begin // see R14
            // a read fault leaves this byte unwritten, so done_q is the count
            o_mem_req <= 1'b0;
            if (i_mem_fault) begin
              o_cmp_status <= drain_move_pkg::ST_PAGE_FAULT;
              o_cmp_result <= i_cap_overlap_copy ? dir_q : 1'b0; // see R17 see R18
              o_cmp_bytes <= done_q; // see R22
              o_cmp_fault_addr <= o_mem_addr;
              state_q <= drain_move_pkg::S_DONE;
            end else begin
              byte_q <= i_mem_rdata;
              state_q <= drain_move_pkg::S_WR;
            end
          end else if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_implicit <= 1'b0;
            o_mem_tc <= 1'b0;
            o_mem_addr <= src_q + cur_off;
          end
        end
        drain_move_pkg::S_WR: begin
          // write the byte just read at the matching destination offset
          if (o_mem_req && i_mem_ready) begin
            o_mem_req <= 1'b0;
            if (i_mem_fault) begin
              o_cmp_status <= drain_move_pkg::ST_PAGE_FAULT;
              o_cmp_result <= i_cap_overlap_copy ? dir_q : 1'b0; // see R17 see R18
              o_cmp_bytes <= done_q; // see R22
              o_cmp_fault_addr <= o_mem_addr;
              state_q <= drain_move_pkg::S_DONE;
            end else if (done_q + XFER_W'(1) == size_q) begin
              // last byte landed: report the full count
              done_q <= size_q;
              o_cmp_bytes <= size_q;
              o_cmp_status <= drain_move_pkg::ST_SUCCESS;
              state_q <= drain_move_pkg::S_DONE;
            end else begin
              done_q <= done_q + XFER_W'(1);
              state_q <= drain_move_pkg::S_RD;
            end
          end else if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b1;
            o_mem_addr <= dst_q + cur_off;
            o_mem_wdata <= byte_q;
          end
        end
        drain_move_pkg::S_DONE: begin
          // one-cycle pulse; result fields stand until the next take
          o_cmp_valid <= 1'b1;
          o_mem_we <= 1'b0;
          state_q <= drain_move_pkg::S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/drain_move_checker.sv ====
// port-level assertions for the drain and move block
`timescale 1ns/1ps
`default_nettype none
module drain_move_checker #(
  parameter int XFER_W = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_desc_valid,
  input wire logic [7:0] i_desc_op,
  input wire logic [23:0] i_desc_flags,
  input wire logic i_desc_in_batch,
  input wire logic i_desc_cache_ctl,
  input wire logic [63:0] i_src_addr,
  input wire logic [63:0] i_dst_addr,
  input wire logic [XFER_W-1:0] i_xfer_size,
  input wire logic i_cap_drain_readback,
  input wire logic i_cap_overlap_copy,
  input wire logic i_mem_ready,
  input wire logic o_desc_ready,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [63:0] o_mem_addr,
  input wire logic o_cmp_valid,
  input wire logic [7:0] o_cmp_status,
  input wire logic o_cmp_result
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  // ------
  // decode at the take edge
  // ------
  logic take;
  logic drain;
  logic ovl;
  assign take = i_desc_valid && o_desc_ready;
  assign drain = take && i_desc_op == drain_move_pkg::OP_DRAIN && !i_desc_in_batch;
  // extra top bit so a region at the top of memory cannot wrap
  assign ovl = {1'b0, i_src_addr} < {1'b0, i_dst_addr} + 65'(i_xfer_size)
    && {1'b0, i_dst_addr} < {1'b0, i_src_addr} + 65'(i_xfer_size);
  // ------
  // assertions
  // ------
  AST_REQ_HOLD: assert property (o_mem_req && !i_mem_ready |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)) else $error("request moved early");
  AST_REQ_DROP: assert property (o_mem_req && i_mem_ready |=> !o_mem_req)
    else $error("request not dropped");
  AST_READY_DROP: assert property (take |=> !o_desc_ready) else $error("ready stayed up");
  AST_PULSE: assert property (o_cmp_valid |=> !o_cmp_valid) else $error("completion too long");
  AST_BAD_OP: assert property (
    take && (i_desc_op == drain_move_pkg::OP_DRAIN ? i_desc_in_batch
    : i_desc_op != drain_move_pkg::OP_MOVE) |-> ##2 o_cmp_valid
    && o_cmp_status == drain_move_pkg::ST_BAD_OP) else $error("unsupported op not refused");
  AST_RSVD: assert property (
    drain && (|i_desc_flags[23:20] || i_desc_cache_ctl) |-> ##2 o_cmp_valid
    && o_cmp_status == drain_move_pkg::ST_BAD_FLAGS) else $error("reserved flag accepted");
  AST_RB_CAP: assert property (
    drain && !i_cap_drain_readback && |i_desc_flags[17:16] |-> ##2 o_cmp_valid
    && o_cmp_status == drain_move_pkg::ST_BAD_FLAGS) else $error("readback without capability");
  AST_OVERLAP: assert property (
    take && i_desc_op == drain_move_pkg::OP_MOVE && !i_desc_in_batch && !i_cap_overlap_copy
    && i_xfer_size != 0 && ovl |-> ##2 o_cmp_valid && !o_cmp_result
    && o_cmp_status == drain_move_pkg::ST_OVERLAP) else $error("overlap not refused");
  AST_DIR_ZERO: assert property (
    o_cmp_valid && o_cmp_status == drain_move_pkg::ST_PAGE_FAULT && !i_cap_overlap_copy
    |-> !o_cmp_result) else $error("direction set without overlap support");
  // main scenarios reached
  cover property (o_cmp_valid && o_cmp_status == drain_move_pkg::ST_PAGE_FAULT);
  cover property (o_mem_req && i_mem_ready && o_mem_we);
  cover property (drain && |i_desc_flags[17:16]);
endmodule
bind drain_and_memory_move_ops drain_move_checker #(.XFER_W(XFER_W)) chk (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_desc_valid(i_desc_valid),
  .i_desc_op(i_desc_op), .i_desc_flags(i_desc_flags), .i_desc_in_batch(i_desc_in_batch),
  .i_desc_cache_ctl(i_desc_cache_ctl), .i_src_addr(i_src_addr), .i_dst_addr(i_dst_addr),
  .i_xfer_size(i_xfer_size), .i_cap_drain_readback(i_cap_drain_readback),
  .i_cap_overlap_copy(i_cap_overlap_copy), .i_mem_ready(i_mem_ready),
  .o_desc_ready(o_desc_ready), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
  .o_mem_addr(o_mem_addr), .o_cmp_valid(o_cmp_valid), .o_cmp_status(o_cmp_status),
  .o_cmp_result(o_cmp_result));
`default_nettype wire

// ==== tb/mem_partner.sv ====
// byte memory model answering the block's memory port
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input wire logic i_sys_clk,
  input wire logic i_mem_req,
  input wire logic i_mem_we,
  input wire logic [63:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  input wire logic [1:0] i_lat,
  input wire logic [63:0] i_fault_addr,
  input wire logic i_fault_en,
  output logic o_mem_ready,
  output logic o_mem_fault,
  output logic [7:0] o_mem_rdata
);
  logic [7:0] mem [256]; // low address byte only
  logic [7:0] last_q;
  logic [1:0] wait_q;
  initial begin
    last_q = 8'h00;
    wait_q = 2'h0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // latency zero answers in the request cycle
  assign o_mem_ready = i_mem_req && wait_q >= i_lat;
  assign o_mem_fault = o_mem_ready && i_fault_en && i_mem_addr == i_fault_addr;
  // outside an answer the data lines show junk, never the old byte
  assign o_mem_rdata = o_mem_ready ? mem[i_mem_addr[7:0]] : ~last_q;
  // a faulting write leaves memory untouched
  always @(posedge i_sys_clk) begin
    wait_q <= (i_mem_req && !o_mem_ready) ? wait_q + 2'h1 : 2'h0;
    if (o_mem_ready) last_q <= o_mem_rdata;
    if (o_mem_ready && i_mem_we && !o_mem_fault) mem[i_mem_addr[7:0]] <= i_mem_wdata;
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the drain and move block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {
    logic [7:0] op;
    logic [23:0] fl;
    logic b, cc, crb, cov;
    logic [7:0] s, d, n, st;
    int nreq;
    logic tc0;
  } row_t;
  logic clk = 1'b0; // starts low so no false falling edge at time zero
  logic rst_b, dv, inb, cc, s1, s2, crb, cov, busy, fen, rdy, flt, dr, rq, we, tc, im;
  logic cv, cres;
  logic [7:0] op, rd, wd, cst;
  logic [23:0] fl;
  logic [63:0] src, dst, fa, ad, cfa;
  logic [31:0] sz, cb;
  logic [1:0] lat;
  logic [7:0] rm [256]; // expected memory image
  logic [10:0] lg [$]; // accepted accesses: implicit, class, write, addr
  int num_errors, num_checks, ncmp;
  // ------
  // ordinary cases: descriptor fields and expected status
  // ------
  row_t rows [12] = '{
    '{8'h03, 0, 0, 0, 0, 1, 8'h11, 8'h43, 8'h05, 8'h01, 10, 0},
    '{8'h03, 0, 0, 0, 0, 1, 8'h20, 8'h22, 8'h06, 8'h01, 12, 0},
    '{8'h03, 0, 0, 0, 0, 0, 8'h30, 8'h32, 8'h04, 8'h11, 0, 0},
    '{8'h03, 0, 0, 0, 0, 0, 8'h30, 8'h32, 8'h00, 8'h01, 0, 0},
    '{8'h07, 0, 0, 0, 0, 0, 8'h00, 8'h00, 8'h00, 8'h10, 0, 0},
    '{8'h02, 24'h0c0000, 1, 0, 1, 0, 0, 0, 0, 8'h10, 0, 0},
    '{8'h02, 24'h1c0000, 0, 0, 1, 0, 0, 0, 0, 8'h12, 0, 0},
    '{8'h02, 24'h0c0000, 0, 1, 1, 0, 0, 0, 0, 8'h12, 0, 0},
    '{8'h02, 24'h010000, 0, 0, 0, 0, 0, 0, 0, 8'h12, 0, 0},
    '{8'h02, 24'h0c0000, 0, 0, 1, 0, 0, 0, 0, 8'h01, 0, 0},
    '{8'h02, 24'h040000, 0, 0, 1, 0, 0, 0, 0, 8'h01, 1, 1},
    '{8'h02, 24'h080000, 0, 0, 1, 0, 0, 0, 0, 8'h01, 1, 0}};
  drain_and_memory_move_ops #(.XFER_W(32)) uut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_desc_valid(dv), .i_desc_op(op), .i_desc_flags(fl),
    .i_desc_in_batch(inb), .i_desc_cache_ctl(cc), .i_rb1_tc_sel(s1), .i_rb2_tc_sel(s2),
    .i_src_addr(src), .i_dst_addr(dst), .i_xfer_size(sz), .i_cap_drain_readback(crb),
    .i_cap_overlap_copy(cov), .i_wq_older_busy(busy), .i_mem_ready(rdy), .i_mem_fault(flt),
    .i_mem_rdata(rd), .o_desc_ready(dr), .o_mem_req(rq), .o_mem_we(we), .o_mem_tc(tc),
    .o_mem_implicit(im), .o_mem_addr(ad), .o_mem_wdata(wd), .o_cmp_valid(cv),
    .o_cmp_status(cst), .o_cmp_result(cres), .o_cmp_bytes(cb), .o_cmp_fault_addr(cfa));
  mem_partner m (.i_sys_clk(clk), .i_mem_req(rq), .i_mem_we(we), .i_mem_addr(ad),
    .i_mem_wdata(wd), .i_lat(lat), .i_fault_addr(fa), .i_fault_en(fen),
    .o_mem_ready(rdy), .o_mem_fault(flt), .o_mem_rdata(rd));
  // ------
  // helpers
  // ------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // offer at a falling edge, hold until taken
  task automatic issue(input row_t r);
    int k;
    @(negedge clk);
    lg.delete();
    ncmp = 0;
    {op, fl, inb, cc, crb, cov} = {r.op, r.fl, r.b, r.cc, r.crb, r.cov};
    src = 64'(r.s);
    dst = 64'(r.d);
    sz = 32'(r.n);
    dv = 1'b1;
    k = 0;
    while (dr !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("taken", 1, dr);
    @(negedge clk);
    dv = 1'b0;
  endtask
  // bounded wait for the completion pulse
  task automatic done();
    int k;
    k = 0;
    while (cv !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk("cmp_valid", 1, cv);
  endtask
  // copy through a temporary buffer, as the overlap rule wants
  task automatic ref_move(input logic [7:0] s, input logic [7:0] d, input logic [7:0] n);
    logic [7:0] t [256];
    for (int i = 0; i < n; i++) t[i] = rm[8'(s + i)];
    for (int i = 0; i < n; i++) rm[8'(d + i)] = t[i];
  endtask
  task automatic memchk();
    for (int i = 0; i < 256; i++) chk("mem", rm[i], m.mem[i]);
  endtask
  always @(posedge clk) begin
    if (rq && rdy) lg.push_back({im, tc, we, ad[7:0]});
    if (cv) ncmp++;
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog: far above the few hundred cycles the tests need
  initial begin
    #4000000;
    num_errors++;
    final_report();
  end
  // ------
  // main sequence
  // ------
  initial begin
    {dv, inb, cc, s1, s2, crb, cov, busy, fen, rst_b} = '0;
    {op, fl, src, dst, sz, fa, lat} = '0;
    num_errors = 0;
    num_checks = 0;
    for (int i = 0; i < 256; i++) rm[i] = 8'(i) ^ 8'h5a;
    repeat (6) begin
      @(negedge clk);
      chk("reset_outs", 0, {dr, rq, cv});
    end
    rst_b = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i]);
      done();
      chk("status", rows[i].st, cst);
      if (rows[i].st == 8'h11) chk("result", 0, cres);
      repeat (2) @(negedge clk);
      chk("accesses", rows[i].nreq, lg.size());
      if (rows[i].nreq == 1) chk("class", rows[i].tc0, lg[0][9]);
      if (rows[i].op == 8'h03 && rows[i].st == 8'h01) begin
        ref_move(rows[i].s, rows[i].d, rows[i].n);
        memchk();
      end
    end
    // drain held back by older work, then two explicit and two implicit readbacks
    busy = 1'b1;
    s1 = 1'b1;
    issue('{8'h02, 24'h030000, 0, 0, 1, 0, 8'h55, 8'h66, 0, 0, 0, 0});
    repeat (20) @(negedge clk);
    chk("held", 0, ncmp + lg.size());
    busy = 1'b0;
    done();
    chk("status", 8'h01, cst);
    chk("rb1", {3'b010, 8'h55}, lg[0]);
    chk("rb2", {3'b000, 8'h66}, lg[1]);
    chk("impl_a", {3'b100, 8'h00}, lg[2]);
    chk("impl_b", {3'b110, 8'h00}, lg[3]);
    s1 = 1'b0;
    // forward move faults on its fourth write with a slow memory, then resumes
    lat = 2'd2;
    fa = 64'hc3;
    fen = 1'b1;
    issue('{8'h03, 0, 0, 0, 0, 0, 8'h80, 8'hc0, 8'h08, 0, 0, 0});
    done();
    chk("fault_st", 8'h03, cst);
    chk("fault_dir", 0, cres);
    chk("fault_bytes", 3, cb);
    chk("fault_addr", 64'hc3, cfa);
    fen = 1'b0;
    issue('{8'h03, 0, 0, 0, 0, 0, 8'h83, 8'hc3, 8'h05, 0, 0, 0});
    done();
    ref_move(8'h80, 8'hc0, 8'h08);
    memchk();
    // overlapping move runs reversed, faults, then resumes with the same addresses
    lat = 2'd0;
    fa = 64'h69;
    fen = 1'b1;
    issue('{8'h03, 0, 0, 0, 0, 1, 8'h60, 8'h64, 8'h08, 0, 0, 0});
    done();
    chk("rev_dir", 1, cres);
    chk("rev_bytes", 2, cb);
    fen = 1'b0;
    issue('{8'h03, 0, 0, 0, 0, 1, 8'h60, 8'h64, 8'h06, 0, 0, 0});
    done();
    ref_move(8'h60, 8'h64, 8'h08);
    memchk();
    final_report();
  end
endmodule
`default_nettype wire
